// ---- bench/testbench.sv ----
// Self-checking bench of the interrupt and FIFO control block
`timescale 1ns/1ps
module testbench;
    import uifc_pkg::*;
    logic          clk_sys  = 1'b0;   // 125 MHz clock
    logic          resetn   = 1'b0;   // Reset, active low
    uifc_req_type  reg_req;           // Host request
    logic [7:0]    reg_rdata, rd_v;   // Read data and value taken
    logic          gate     = 1'b0;   // Enhanced gate
    uifc_fifo_type fifo_stat = '0;    // FIFO state
    logic [4:0]    line_err = '0;     // Line error levels
    logic [3:0]    mdm_dlt  = '0;     // Modem change pulses
    logic [7:0]    gpio     = '0;     // General inputs
    logic [7:0]    pulse    = '0;     // Xoff, special, xon, push, rx read, tx write, modem, pins
    logic [4:0]    flow     = 5'h18;  // Pin levels high, automatic modes off
    logic          tick     = 1'b0;   // Bit-time pulse
    logic          irq_n, sleep_enable, fifo_enable, rx_fifo_reset, tx_fifo_reset; // Outputs
    logic [6:0]    rx_trigger, tx_trigger;  // Trigger outputs
    int            err_count = 0, checked = 0, cyc = 0; // Counters
    // Clock
    always #4 clk_sys = ~clk_sys;
    uifc_host host (.clk_sys(clk_sys), .rdata(reg_rdata), .req(reg_req));
    uifc_ctrl uut (.clk_sys(clk_sys), .resetn(resetn), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .enhanced_feature_gate(gate), .fifo_stat(fifo_stat), .rx_push(pulse[4]),
        .receive_holding_read(pulse[3]), .transmit_holding_write(pulse[2]),
        .modem_status_read(pulse[1]), .pin_input_state_read(pulse[0]), .bit_tick(tick),
        .char_bits(4'hA), .line_status_err(line_err), .modem_status_delta(mdm_dlt),
        .gpio_in(gpio), .xoff_detect(pulse[7]), .special_detect(pulse[6]), .xon_detect(pulse[5]),
        .rts_n(flow[4]), .cts_n(flow[3]), .auto_rts(flow[2]), .auto_cts(flow[1]),
        .rs485_auto(flow[0]), .irq_n(irq_n), .sleep_enable(sleep_enable),
        .fifo_enable(fifo_enable), .rx_fifo_reset(rx_fifo_reset),
        .tx_fifo_reset(tx_fifo_reset), .rx_trigger(rx_trigger), .tx_trigger(tx_trigger));
    // Compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Verdict and end of run
    task automatic stop_test();
        $display("Mismatches %0d in %0d checks", err_count, checked);
        if (err_count == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            stop_test();
        end
    end
    // One-cycle pulse on a side input
    task automatic pls(input int i);
        @(posedge clk_sys) pulse[i] <= 1'b1;
        @(posedge clk_sys) pulse[i] <= 1'b0;
    endtask
    // Let register and interrupt pipelines land
    task automatic settle();
        repeat (4) @(posedge clk_sys);
    endtask
    // Cycles with a FIFO reset high, summed over both FIFOs
    task automatic cnt_rst(output int n);
        n = 0;
        repeat (8) begin
            #1 n += rx_fifo_reset + tx_fifo_reset;
            @(posedge clk_sys);
        end
    endtask
    // Reset status, gating of enhanced enable bits, unmapped read
    task automatic t_reset_gate();
        host.rd(OFS_STATUS_CONTROL, rd_v);
        check(rd_v, 8'h01);
        host.wr(OFS_INTERRUPT_ENABLE, 8'hF0);
        host.rd(OFS_INTERRUPT_ENABLE, rd_v);
        check(rd_v, IE_RESET);
        @(posedge clk_sys) gate <= 1'b1;
        host.wr(OFS_INTERRUPT_ENABLE, 8'h30);
        host.rd(OFS_INTERRUPT_ENABLE, rd_v);
        check(rd_v, 8'h30);
        check({7'h0, sleep_enable}, 8'h01);
        host.rd(3'h7, rd_v);
        check(rd_v, 8'h00);
    endtask
    // Trigger tables, FIFO status bits, gating, FIFO resets, disable
    task automatic t_fifo();
        logic [6:0] rxl [4] = '{RX_TRIG_0, RX_TRIG_1, RX_TRIG_2, RX_TRIG_3};
        logic [6:0] txl [4] = '{TX_TRIG_0, TX_TRIG_1, TX_TRIG_2, TX_TRIG_3};
        int n;
        for (int i = 0; i < 4; i++) begin
            host.wr(OFS_STATUS_CONTROL, {2'(i), 2'(i), 4'h9});
            settle();
            check({1'b0, rx_trigger}, {1'b0, rxl[i]});
            check({1'b0, tx_trigger}, {1'b0, txl[i]});
        end
        host.rd(OFS_STATUS_CONTROL, rd_v);
        check(rd_v & 8'hC0, 8'hC0);
        @(posedge clk_sys) gate <= 1'b0;
        host.wr(OFS_STATUS_CONTROL, 8'h09);
        settle();
        check({1'b0, tx_trigger}, {1'b0, TX_TRIG_3});
        @(posedge clk_sys) gate <= 1'b1;
        host.wr(OFS_STATUS_CONTROL, 8'hC7);
        cnt_rst(n);
        check(8'(n), 8'h06);
        host.wr(OFS_STATUS_CONTROL, 8'h06);
        cnt_rst(n);
        check(8'(n), 8'h00);
        check({fifo_enable, rx_trigger}, {1'b0, RX_TRIG_3});
    endtask
    // Priority order and clearing of line, modem and input sources
    task automatic t_prio();
        host.wr(OFS_INTERRUPT_ENABLE, 8'h0C);
        @(posedge clk_sys) line_err <= 5'h01;
        mdm_dlt <= 4'h1;
        gpio <= 8'h01;
        @(posedge clk_sys) mdm_dlt <= 4'h0;
        settle();
        host.rd(OFS_STATUS_CONTROL, rd_v);
        check(rd_v, {2'b00, CODE_LINE});
        @(posedge clk_sys) line_err <= 5'h00;
        settle();
        host.rd(OFS_STATUS_CONTROL, rd_v);
        check(rd_v, {2'b00, CODE_MODEM});
        pls(1);
        settle();
        host.rd(OFS_STATUS_CONTROL, rd_v);
        check(rd_v, {2'b00, CODE_GPIO});
        pls(0);
        settle();
        check({7'h0, irq_n}, 8'h01);
    endtask
    // Transmit ready with FIFOs off, cleared by a status read
    task automatic t_tx();
        @(posedge clk_sys) fifo_stat.thr_empty <= 1'b1;
        host.wr(OFS_INTERRUPT_ENABLE, 8'h02);
        settle();
        check({7'h0, irq_n}, 8'h00);
        host.rd(OFS_STATUS_CONTROL, rd_v);
        check(rd_v, {2'b00, CODE_TX_RDY});
        settle();
        check({7'h0, irq_n}, 8'h01);
    endtask
    // Receive time-out, cleared by a holding read, then data ready
    task automatic t_rx();
        host.wr(OFS_INTERRUPT_ENABLE, 8'h01);
        host.wr(OFS_STATUS_CONTROL, 8'h01);
        @(posedge clk_sys) fifo_stat.rx_level <= 7'h01;
        tick <= 1'b1;
        repeat (52) @(posedge clk_sys); // 4 x 10 + 12 ticks
        check({7'h0, irq_n}, 8'h01);
        host.rd(OFS_STATUS_CONTROL, rd_v);
        check(rd_v, {2'b11, CODE_RX_TOUT});
        pls(3);
        @(posedge clk_sys) fifo_stat.rx_level <= 7'h09;
        settle();
        host.rd(OFS_STATUS_CONTROL, rd_v);
        check(rd_v, {2'b11, CODE_RX_DATA});
    endtask
    // Main sequence
    initial begin
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        t_reset_gate();
        t_fifo();
        t_prio();
        t_tx();
        t_rx();
        stop_test();
    end
endmodule

// ---- bench/uifc_ctrl_assertions.sv ----
// Port checker of the interrupt and FIFO control block
`timescale 1ns/1ps
module uifc_ctrl_assertions (
    input wire logic                   clk_sys,               // Clock
    input wire logic                   resetn,                // Reset, active low
    input wire uifc_pkg::uifc_req_type reg_req,               // Register request
    input wire logic [7:0]             reg_rdata,             // Read data
    input wire logic                   enhanced_feature_gate, // Gate
    input wire logic                   irq_n,                 // Interrupt, active low
    input wire logic                   sleep_enable,          // Sleep mode
    input wire logic                   fifo_enable,           // FIFOs on
    input wire logic                   rx_fifo_reset,         // RX pointer reset
    input wire logic                   tx_fifo_reset,         // TX pointer reset
    input wire logic [6:0]             rx_trigger,            // RX trigger
    input wire logic [6:0]             tx_trigger             // TX trigger
);
    import uifc_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // Decoded accesses
    wire logic wr_ie = reg_req.wr && (reg_req.addr == OFS_INTERRUPT_ENABLE);
    wire logic wr_fc = reg_req.wr && (reg_req.addr == OFS_STATUS_CONTROL);
    wire logic rd_st = reg_req.rd && (reg_req.addr == OFS_STATUS_CONTROL);
    // Own decode of the RX trigger table, kept apart from the design
    function automatic logic [6:0] rx_lvl(input logic [1:0] c);
        return c[1] ? (c[0] ? RX_TRIG_3 : RX_TRIG_2) : (c[0] ? RX_TRIG_1 : RX_TRIG_0);
    endfunction
    property p_sleep; wr_ie && enhanced_feature_gate |=>
        sleep_enable == $past(reg_req.wdata[4]); endproperty
    a_sleep: assert property (p_sleep) else $error("sleep enable not written");
    property p_gate; wr_ie && !enhanced_feature_gate |=> $stable(sleep_enable); endproperty
    a_gate: assert property (p_gate) else $error("gated enable bit changed");
    property p_rxrst; wr_fc && reg_req.wdata[1:0] == 2'b11 |=>
        rx_fifo_reset [*3] ##1 !rx_fifo_reset; endproperty
    a_rxrst: assert property (p_rxrst) else $error("rx reset not three cycles");
    property p_txrst; wr_fc && reg_req.wdata[2] && reg_req.wdata[0] |=>
        tx_fifo_reset [*3] ##1 !tx_fifo_reset; endproperty
    a_txrst: assert property (p_txrst) else $error("tx reset not three cycles");
    property p_off; wr_fc && !reg_req.wdata[0] |=>
        !fifo_enable && !rx_fifo_reset && $stable(rx_trigger); endproperty
    a_off: assert property (p_off) else $error("write with fifos off took effect");
    property p_rxtrig; wr_fc && reg_req.wdata[0] |=>
        rx_trigger == rx_lvl($past(reg_req.wdata[7:6])); endproperty
    a_rxtrig: assert property (p_rxtrig) else $error("rx trigger wrong");
    property p_txgate; wr_fc && !enhanced_feature_gate |=> $stable(tx_trigger); endproperty
    a_txgate: assert property (p_txgate) else $error("tx trigger changed without gate");
    property p_st67; rd_st |=> reg_rdata[7:6] == {2{$past(fifo_enable)}}; endproperty
    a_st67: assert property (p_st67) else $error("fifo status bits wrong");
    property p_none; rd_st |=> (reg_rdata[5:0] == CODE_NONE) == $past(irq_n); endproperty
    a_none: assert property (p_none) else $error("pending code and interrupt disagree");
endmodule
bind uifc_ctrl uifc_ctrl_assertions u_chk (.clk_sys(clk_sys), .resetn(resetn), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .enhanced_feature_gate(enhanced_feature_gate), .irq_n(irq_n),
    .sleep_enable(sleep_enable), .fifo_enable(fifo_enable), .rx_fifo_reset(rx_fifo_reset),
    .tx_fifo_reset(tx_fifo_reset), .rx_trigger(rx_trigger), .tx_trigger(tx_trigger));

// ---- bench/uifc_host.sv ----
// Host model that drives the register port of the block
`timescale 1ns/1ps
module uifc_host (
    input  wire logic              clk_sys, // Bus clock
    input  wire logic [7:0]        rdata,   // Read data from the block
    output uifc_pkg::uifc_req_type req      // Register request
);
    import uifc_pkg::*;
    // Bus idle until the first call
    initial req = '0;
    // Write strobe for one cycle, launched just after an edge
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_sys);
        req <= '0;
    endtask
    // Read strobe; the registered answer is taken one edge after the strobe is taken
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_sys);
        req <= '0;
        @(posedge clk_sys);
        #1 d = rdata;
    endtask
endmodule

// ---- include/uifc_pkg.sv ----
// Constants, register offsets and carrier types of the interrupt and FIFO control block
package uifc_pkg;

    // Register offsets on the UART register port
    localparam logic [2:0] OFS_INTERRUPT_ENABLE = 3'h1;
    localparam logic [2:0] OFS_STATUS_CONTROL   = 3'h2;   // Status on read, FIFO control on write

    // Interrupt enable bit positions
    localparam int IE_RX_DATA  = 0;
    localparam int IE_TX_READY = 1;
    localparam int IE_LINE     = 2;
    localparam int IE_MODEM    = 3;
    localparam int IE_SLEEP    = 4;
    localparam int IE_XOFF     = 5;
    localparam int IE_RTS      = 6;
    localparam int IE_CTS      = 7;
    localparam logic [7:0] IE_RESET      = 8'h00;
    localparam logic [7:0] IE_GATED_MASK = 8'hF0;   // Bits that need the enhanced gate

    // FIFO control bit positions and fields
    localparam int FC_ENABLE   = 0;
    localparam int FC_RX_RESET = 1;
    localparam int FC_TX_RESET = 2;
    localparam int FC_TX_TRIG  = 4;
    localparam int FC_RX_TRIG  = 6;
    localparam logic [1:0] TRIG_RESET = 2'h0;

    // Status bit positions
    localparam int ST_FIFO_LO = 6;

    // Status source codes, bits 5 to 0
    localparam logic [5:0] CODE_LINE    = 6'h06;
    localparam logic [5:0] CODE_RX_TOUT = 6'h0C;
    localparam logic [5:0] CODE_RX_DATA = 6'h04;
    localparam logic [5:0] CODE_TX_RDY  = 6'h02;
    localparam logic [5:0] CODE_MODEM   = 6'h00;
    localparam logic [5:0] CODE_GPIO    = 6'h30;
    localparam logic [5:0] CODE_XOFF    = 6'h10;
    localparam logic [5:0] CODE_FLOW    = 6'h20;
    localparam logic [5:0] CODE_NONE    = 6'h01;

    // Trigger levels in entries
    localparam logic [6:0] TX_TRIG_0 = 7'h08;   // 8 spaces
    localparam logic [6:0] TX_TRIG_1 = 7'h10;   // 16 spaces
    localparam logic [6:0] TX_TRIG_2 = 7'h20;   // 32 spaces
    localparam logic [6:0] TX_TRIG_3 = 7'h38;   // 56 spaces
    localparam logic [6:0] RX_TRIG_0 = 7'h08;   // 8 characters
    localparam logic [6:0] RX_TRIG_1 = 7'h10;   // 16 characters
    localparam logic [6:0] RX_TRIG_2 = 7'h38;   // 56 characters
    localparam logic [6:0] RX_TRIG_3 = 7'h3C;   // 60 characters
    localparam logic [6:0] FIFO_DEPTH = 7'h40;  // 64 entries

    // FIFO reset hold, in system clocks
    localparam int         FIFO_RESET_CLOCKS = 3;
    localparam logic [1:0] FIFO_RESET_CYCLES = 2'(FIFO_RESET_CLOCKS);

    // Receive time-out: four characters plus twelve bit times
    localparam logic [6:0] TOUT_CHARS = 7'h04;
    localparam logic [6:0] TOUT_BITS  = 7'h0C;

    // Number of interrupt sources
    localparam int NUM_SRC = 8;

    // Priority levels, highest first after none
    typedef enum logic [3:0] {
        SRC_NONE, SRC_LINE, SRC_RX_TOUT, SRC_RX_DATA, SRC_TX_RDY,
        SRC_MODEM, SRC_GPIO, SRC_XOFF, SRC_FLOW
    } uifc_src_type;

    // Register port request
    typedef struct packed {
        logic       wr;      // Write strobe
        logic       rd;      // Read strobe
        logic [2:0] addr;    // Register offset
        logic [7:0] wdata;   // Write data
    } uifc_req_type;

    // FIFO and transmitter state from the datapath
    typedef struct packed {
        logic [6:0] rx_level;   // Characters held in RX FIFO
        logic [6:0] tx_level;   // Characters held in TX FIFO
        logic       thr_empty;  // Holding register empty
        logic       tx_empty;   // Transmitter fully empty
    } uifc_fifo_type;

endpackage

// ---- verilog/uifc_ctrl.sv ----
// Interrupt prioritisation and FIFO control of the UART
`timescale 1ns/1ps
module uifc_ctrl (
    input  wire logic                   clk_sys,               // System clock, 125 MHz
    input  wire logic                   resetn,                // Asynchronous reset, active low
    input  wire uifc_pkg::uifc_req_type reg_req,               // Register port request
    output logic [7:0]                  reg_rdata,             // Registered read data
    input  wire logic                   enhanced_feature_gate, // Enhanced-function gate
    input  wire uifc_pkg::uifc_fifo_type fifo_stat,            // FIFO and transmitter state
    input  wire logic                   rx_push,               // Character entered RX FIFO
    input  wire logic                   receive_holding_read,  // Receive holding read pulse
    input  wire logic                   transmit_holding_write,// Transmit holding write pulse
    input  wire logic                   modem_status_read,     // Modem status read pulse
    input  wire logic                   pin_input_state_read,  // Input state read pulse
    input  wire logic                   bit_tick,              // One pulse per bit time
    input  wire logic [3:0]             char_bits,             // Bits per character frame
    input  wire logic [4:0]             line_status_err,       // Line status bits 7,4,3,2,1
    input  wire logic [3:0]             modem_status_delta,    // Modem change pulses
    input  wire logic [7:0]             gpio_in,               // General-purpose inputs
    input  wire logic                   xoff_detect,           // Xoff matched pulse
    input  wire logic                   special_detect,        // Special character pulse
    input  wire logic                   xon_detect,            // Xon matched pulse
    input  wire logic                   rts_n,                 // Request-to-send pin level
    input  wire logic                   cts_n,                 // Clear-to-send pin level
    input  wire logic                   auto_rts,              // Automatic RTS flow on
    input  wire logic                   auto_cts,              // Automatic CTS flow on
    input  wire logic                   rs485_auto,            // Auto RS-485 direction on
    output logic                        irq_n,                 // Interrupt, active low
    output logic                        sleep_enable,          // Sleep mode enabled
    output logic                        fifo_enable,           // Both FIFOs enabled
    output logic                        rx_fifo_reset,         // RX FIFO pointer reset
    output logic                        tx_fifo_reset,         // TX FIFO pointer reset
    output logic [6:0]                  rx_trigger,            // RX trigger in characters
    output logic [6:0]                  tx_trigger             // TX trigger in spaces
);
    import uifc_pkg::*;

    logic [7:0]   ie_q;          // Interrupt enable register
    logic         fifo_en_q;     // FIFO enable
    logic [1:0]   tx_trig_q;     // TX trigger select
    logic [1:0]   rx_trig_q;     // RX trigger select
    logic [1:0]   rx_rst_cnt_q;  // RX reset hold counter
    logic [1:0]   tx_rst_cnt_q;  // TX reset hold counter
    logic [7:0]   rdata_q;       // Read data
    logic [6:0]   tout_cnt_q;    // Bit times since last RX activity
    logic         tout_q;        // Receive time-out pending
    logic         tx_rdy_q;      // Transmit ready pending
    logic         tx_cond_q;     // Previous transmit-ready condition
    logic         modem_q;       // Modem status pending
    logic         gpio_q;        // Input toggle pending
    logic [7:0]   gpio_prev_q;   // Previous input levels
    logic         xoff_q;        // Xoff pending
    logic         special_q;     // Special character pending
    logic         flow_q;        // RTS/CTS change pending
    logic         rts_prev_q;    // Previous RTS level
    logic         cts_prev_q;    // Previous CTS level
    uifc_src_type shown_q;       // Source being serviced
    uifc_src_type shown_d;       // Next source to show
    logic [NUM_SRC-1:0] pend;    // Pending, index 0 is level 1
    logic [5:0]   code;          // Status code of shown source
    logic         wr_ie;         // Enable register write
    logic         wr_fc;         // FIFO control write
    logic         rd_st;         // Status register read
    logic         line_act;      // Line status interrupt level
    logic         rx_data_act;   // Data ready interrupt level
    logic [6:0]   tx_space;      // Free spaces in TX FIFO
    logic         tx_cond;       // Transmit-ready condition
    logic [6:0]   tout_limit;    // Time-out length in bit times

    // Register port decode
    assign wr_ie = reg_req.wr && (reg_req.addr == OFS_INTERRUPT_ENABLE);
    assign wr_fc = reg_req.wr && (reg_req.addr == OFS_STATUS_CONTROL);
    assign rd_st = reg_req.rd && (reg_req.addr == OFS_STATUS_CONTROL);

    // Interrupt enable register; the upper nibble is locked without the gate
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ie_q <= IE_RESET;
        end else if (wr_ie) begin
            if (enhanced_feature_gate) begin
                ie_q <= reg_req.wdata;
            end else begin
                ie_q <= (ie_q & IE_GATED_MASK) | (reg_req.wdata & ~IE_GATED_MASK);
            end
        end
    end
    assign sleep_enable = ie_q[IE_SLEEP];

    // FIFO control register; nothing but the enable moves while bit 0 is clear
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            fifo_en_q <= 1'b0;
            tx_trig_q <= TRIG_RESET;
            rx_trig_q <= TRIG_RESET;
        end else if (wr_fc) begin
            fifo_en_q <= reg_req.wdata[FC_ENABLE];
            if (reg_req.wdata[FC_ENABLE]) begin
                rx_trig_q <= reg_req.wdata[FC_RX_TRIG +: 2];
                if (enhanced_feature_gate) begin
                    tx_trig_q <= reg_req.wdata[FC_TX_TRIG +: 2];
                end
            end
        end
    end

    // FIFO reset pulses; held three clocks so slow pointer logic sees them
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rx_rst_cnt_q <= 2'h0;
            tx_rst_cnt_q <= 2'h0;
        end else begin
            if (wr_fc && reg_req.wdata[FC_ENABLE] && reg_req.wdata[FC_RX_RESET]) begin
                rx_rst_cnt_q <= FIFO_RESET_CYCLES;
            end else if (rx_rst_cnt_q != 2'h0) begin
                rx_rst_cnt_q <= rx_rst_cnt_q - 2'h1;
            end
            if (wr_fc && reg_req.wdata[FC_ENABLE] && reg_req.wdata[FC_TX_RESET]) begin
                tx_rst_cnt_q <= FIFO_RESET_CYCLES;
            end else if (tx_rst_cnt_q != 2'h0) begin
                tx_rst_cnt_q <= tx_rst_cnt_q - 2'h1;
            end
        end
    end

    assign rx_fifo_reset = (rx_rst_cnt_q != 2'h0);
    assign tx_fifo_reset = (tx_rst_cnt_q != 2'h0);
    assign fifo_enable   = fifo_en_q;
    // Trigger level lookup
    always_comb begin
        unique case (rx_trig_q)
            2'h0: rx_trigger = RX_TRIG_0;
            2'h1: rx_trigger = RX_TRIG_1;
            2'h2: rx_trigger = RX_TRIG_2;
            2'h3: rx_trigger = RX_TRIG_3;
        endcase
        unique case (tx_trig_q)
            2'h0: tx_trigger = TX_TRIG_0;
            2'h1: tx_trigger = TX_TRIG_1;
            2'h2: tx_trigger = TX_TRIG_2;
            2'h3: tx_trigger = TX_TRIG_3;
        endcase
    end
    // Level sources; they follow their cause, so no clear is needed
    // line error level
    assign line_act    = ie_q[IE_LINE] && (|line_status_err);
    assign rx_data_act = ie_q[IE_RX_DATA] && (fifo_en_q ? (fifo_stat.rx_level > rx_trigger)
                                                        : (fifo_stat.rx_level != 7'h00));
    assign tx_space    = FIFO_DEPTH - fifo_stat.tx_level;
    assign tx_cond = (fifo_en_q ? ((tx_space > tx_trigger) || (fifo_stat.tx_level == 7'h00))
                                : fifo_stat.thr_empty)
                     || (rs485_auto && fifo_stat.tx_empty);
    assign tout_limit = 7'(TOUT_CHARS * {3'h0, char_bits}) + TOUT_BITS;
    // Receive time-out timer; restarted by any RX traffic or read
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tout_cnt_q <= 7'h00;
            tout_q     <= 1'b0;
        end else begin
            if (rx_push || receive_holding_read || fifo_stat.rx_level == 7'h00) begin
                tout_cnt_q <= 7'h00;
            end else if (bit_tick && tout_cnt_q != tout_limit) begin
                tout_cnt_q <= tout_cnt_q + 7'h01;
            end
            if (ie_q[IE_RX_DATA] && bit_tick && !rx_push && fifo_stat.rx_level != 7'h00
                && tout_cnt_q == tout_limit - 7'h01) begin
                tout_q <= 1'b1;
            end else if (receive_holding_read) begin
                tout_q <= 1'b0;
            end
        end
    end
    // Transmit ready; raised on entering the condition or on enabling it
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tx_rdy_q  <= 1'b0;
            tx_cond_q <= 1'b0;
        end else begin
            tx_cond_q <= tx_cond && ie_q[IE_TX_READY];
            if (tx_cond && ie_q[IE_TX_READY] && !tx_cond_q) begin
                tx_rdy_q <= 1'b1;
            end else if (transmit_holding_write || (rd_st && shown_q == SRC_TX_RDY)) begin
                tx_rdy_q <= 1'b0;
            end
        end
    end
    // Modem, input and flow-control events
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            modem_q     <= 1'b0;
            gpio_q      <= 1'b0;
            gpio_prev_q <= 8'h00;
            flow_q      <= 1'b0;
            rts_prev_q  <= 1'b1;   // Pins idle high; no edge at release
            cts_prev_q  <= 1'b1;
        end else begin
            gpio_prev_q <= gpio_in;
            rts_prev_q  <= rts_n;
            cts_prev_q  <= cts_n;
            if (ie_q[IE_MODEM] && (|modem_status_delta)) begin
                modem_q <= 1'b1;
            end else if (modem_status_read) begin
                modem_q <= 1'b0;
            end
            if (gpio_in != gpio_prev_q) begin
                gpio_q <= 1'b1;
            end else if (pin_input_state_read) begin
                gpio_q <= 1'b0;
            end
            if (enhanced_feature_gate
                && ((ie_q[IE_RTS] && auto_rts && rts_n && !rts_prev_q)
                 || (ie_q[IE_CTS] && auto_cts && cts_n && !cts_prev_q))) begin
                flow_q <= 1'b1;
            end else if (modem_status_read) begin
                flow_q <= 1'b0;
            end
        end
    end
    // Xoff and special character; each has its own way out
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            xoff_q    <= 1'b0;
            special_q <= 1'b0;
        end else begin
            if (enhanced_feature_gate && ie_q[IE_XOFF] && xoff_detect) begin
                xoff_q <= 1'b1;
            end else if (xon_detect) begin
                xoff_q <= 1'b0;
            end
            if (enhanced_feature_gate && ie_q[IE_XOFF] && special_detect) begin
                special_q <= 1'b1;
            end else if (rd_st && shown_q == SRC_XOFF) begin
                special_q <= 1'b0;
            end
        end
    end
    // Pending vector in priority order
    assign pend = {flow_q, xoff_q || special_q, gpio_q, modem_q,
                   tx_rdy_q, rx_data_act, tout_q, line_act};
    // Shown source holds until it is serviced; only then is a new one picked
    always_comb begin
        shown_d = shown_q;
        if (shown_q == SRC_NONE || !pend[int'(shown_q) - 1]) begin
            shown_d = SRC_NONE;
            for (int i = NUM_SRC - 1; i >= 0; i--) begin
                if (pend[i]) begin
                    shown_d = uifc_src_type'(4'(i + 1));
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            shown_q <= SRC_NONE;
        end else begin
            shown_q <= shown_d;
        end
    end
    // Status code of the shown source
    always_comb begin
        unique case (shown_q)
            SRC_LINE:    code = CODE_LINE;
            SRC_RX_TOUT: code = CODE_RX_TOUT;
            SRC_RX_DATA: code = CODE_RX_DATA;
            SRC_TX_RDY:  code = CODE_TX_RDY;
            SRC_MODEM:   code = CODE_MODEM;
            SRC_GPIO:    code = CODE_GPIO;
            SRC_XOFF:    code = CODE_XOFF;
            SRC_FLOW:    code = CODE_FLOW;
            default:     code = CODE_NONE;
        endcase
    end
    // Read data; FIFO control is write-only, so that offset returns status
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= 8'h00;
        end else if (reg_req.rd) begin
            if (reg_req.addr == OFS_INTERRUPT_ENABLE) begin
                rdata_q <= ie_q;
            end else if (reg_req.addr == OFS_STATUS_CONTROL) begin
                rdata_q <= {{2{fifo_en_q}}, code};
            end else begin
                rdata_q <= 8'h00;
            end
        end
    end
    assign reg_rdata = rdata_q;
    assign irq_n = (shown_q == SRC_NONE);

endmodule
